//--- core/dual_timer.sv
// Purpose: Two count-up timer/event counters behind a Wishbone slave.
// Assumes: Classic Wishbone, 32-bit data, byte data on lane 0.
// Notes:   Unmapped addresses ack with zero data and ignore writes.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps

// What this block does
// - Counter 0 prescaler code n divides system clock by 2^(n+1).
// - Counter 0 control bit 3 picks edge: 0 rising, 1 falling.
// - Counter 0 control bit 4 is its run bit.
// - Mode bits 7:6: 01 event, 10 timer, 11 pulse width, 00 unused.
// - Low byte write fills buffer; high write loads 16-bit preload.
// - High byte read captures low byte into buffer for later read.
// - Counter 1 uses pin in event mode, instruction clock in timer and pulse modes.
// - Counter 1 overflow past FFFF reloads preload and sets flag bit 6.
// - Pulse mode counts from active edge until pin returns; clears run.
// - After a measurement, wait for run set and a fresh edge.
// - Overflow in pulse mode reloads and raises request as usual.
// - Counter 1 run bit 4 auto-clears only at pulse measurement end.
// - Counter 1 overflow is a wake-up source.
// - Counter 1 enable bit at 0 blocks its interrupt in every mode.
// - Stopped: preload write loads counter too; running: preload only.
// - Reading counter 1 high byte holds its count for that cycle.
// - Counter 1 control bit 3 picks edge: 0 rising, 1 falling.
// - Control bits 2:0 and 5 of counter 1, bit 5 of counter 0 read 0.
// - Counter 1 run bit 1 enables counting, 0 disables it.
// - Counter 0 overflow past FF reloads preload and sets flag bit 5.
// - Counter 1 is 16 bits; clock from pin or system clock / 4.
// - Counter 0 running: writes go to preload; stopped: counter too.
module dual_timer (
	// Clock, enable and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Counter input pins
	input  wire logic        counter0_input_pin_i,
	input  wire logic        counter1_input_pin_i,
	// Interrupt requests and wake-up
	output logic             counter0_irq_o,
	output logic             counter1_irq_o,
	output logic             wake_o
);
	import timer_pkg::*;

	// Bus decode
	logic       take;
	logic       wr;
	logic       rd;
	logic [4:0] idx;
	logic       mapped_hi;
	logic [7:0] wbyte;
	logic [7:0] rbyte;

	assign take      = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign idx       = wb_adr_i[6:2];
	assign mapped_hi = !wb_adr_i[7];
	assign wr        = take && wb_we_i && wb_sel_i[0] && mapped_hi;
	assign rd        = take && !wb_we_i && mapped_hi;
	assign wbyte     = wb_dat_i[7:0];

	logic wr_interrupt_control;
	logic wr_c0_cnt;
	logic wr_c0_ctrl;
	logic wr_c1_high;
	logic wr_c1_low;
	logic wr_c1_ctrl;
	logic rd_c0_cnt;
	logic rd_c1_high;

	assign wr_interrupt_control    = wr && (idx == IDX_INTERRUPT_CONTROL);
	assign wr_c0_cnt  = wr && (idx == IDX_C0_COUNT);
	assign wr_c0_ctrl = wr && (idx == IDX_C0_CTRL);
	assign wr_c1_high = wr && (idx == IDX_C1_HIGH);
	assign wr_c1_low  = wr && (idx == IDX_C1_LOW);
	assign wr_c1_ctrl = wr && (idx == IDX_C1_CTRL);
	assign rd_c0_cnt  = rd && (idx == IDX_C0_COUNT);
	assign rd_c1_high = rd && (idx == IDX_C1_HIGH);

	// Registers
	logic [7:0]  interrupt_control_q;
	logic [7:0]  c0_ctrl_q;
	logic [7:0]  c0_cnt_q;
	logic [7:0]  c0_pre_q;
	logic [7:0]  c1_ctrl_q;
	logic [15:0] c1_cnt_q;
	logic [15:0] c1_pre_q;
	logic [7:0]  c1_buf_q;
	pw_state_e   c0_pw_q;
	pw_state_e   c1_pw_q;

	// Pin synchronisers and clock sources
	logic c0_pin;
	logic c1_pin;
	logic c0_pin_prev_q;
	logic c1_pin_prev_q;
	logic c0_tick;
	logic c1_tick;

	pin_sync u_sync0 (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.pin_i   (counter0_input_pin_i),
		.level_o (c0_pin)
	);

	pin_sync u_sync1 (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.pin_i   (counter1_input_pin_i),
		.level_o (c1_pin)
	);

	tick_divider u_psc0 (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.div_sel_i (c0_ctrl_q[PSC_LSB+:3]),
		.tick_o    (c0_tick)
	);

	tick_divider u_instr (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.div_sel_i (INSTR_DIV_SEL),
		.tick_o    (c1_tick)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c0_pin_prev_q <= 1'b0;
			c1_pin_prev_q <= 1'b0;
		end else if (ce_i) begin
			c0_pin_prev_q <= c0_pin;
			c1_pin_prev_q <= c1_pin;
		end
	end

	// Edge detection, edge choice per control bit 3
	logic [1:0] c0_mode;
	logic [1:0] c1_mode;
	logic       c0_run;
	logic       c1_run;
	logic       c0_act;
	logic       c0_ret;
	logic       c1_act;
	logic       c1_ret;

	assign c0_mode = c0_ctrl_q[MODE_LSB+:2];
	assign c1_mode = c1_ctrl_q[MODE_LSB+:2];
	assign c0_run  = c0_ctrl_q[RUN_BIT];
	assign c1_run  = c1_ctrl_q[RUN_BIT];
	assign c0_act  = c0_ctrl_q[EDGE_BIT] ? (c0_pin_prev_q && !c0_pin)
		: (!c0_pin_prev_q && c0_pin);
	assign c0_ret  = c0_ctrl_q[EDGE_BIT] ? (!c0_pin_prev_q && c0_pin)
		: (c0_pin_prev_q && !c0_pin);
	assign c1_act  = c1_ctrl_q[EDGE_BIT] ? (c1_pin_prev_q && !c1_pin)
		: (!c1_pin_prev_q && c1_pin);
	assign c1_ret  = c1_ctrl_q[EDGE_BIT] ? (!c1_pin_prev_q && c1_pin)
		: (c1_pin_prev_q && !c1_pin);

	// Count steps; a read of the count register blocks the step
	logic c0_step;
	logic c1_step;
	logic c0_ovf;
	logic c1_ovf;
	logic c0_pw_done;
	logic c1_pw_done;

	always_comb begin
		c0_step = 1'b0;
		unique case (c0_mode)
			MODE_EVENT:  c0_step = c0_run && c0_act;
			MODE_TIMER:  c0_step = c0_run && c0_tick;
			MODE_PULSE:  c0_step = c0_run && c0_tick && (c0_pw_q == PW_COUNT);
			MODE_UNUSED: c0_step = 1'b0;
		endcase
		if (rd_c0_cnt) begin
			c0_step = 1'b0;
		end
	end

	always_comb begin
		c1_step = 1'b0;
		unique case (c1_mode)
			MODE_EVENT:  c1_step = c1_run && c1_act;
			MODE_TIMER:  c1_step = c1_run && c1_tick;
			MODE_PULSE:  c1_step = c1_run && c1_tick && (c1_pw_q == PW_COUNT);
			MODE_UNUSED: c1_step = 1'b0;
		endcase
		if (rd_c1_high) begin
			c1_step = 1'b0;
		end
	end

	assign c0_ovf     = c0_step && (c0_cnt_q == 8'hFF);
	assign c1_ovf     = c1_step && (c1_cnt_q == 16'hFFFF);
	assign c0_pw_done = (c0_pw_q == PW_COUNT) && c0_ret && c0_run;
	assign c1_pw_done = (c1_pw_q == PW_COUNT) && c1_ret && c1_run;

	// Pulse-width sequencing: armed only by a run set, started by an edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c0_pw_q <= PW_IDLE;
		end else if (ce_i) begin
			if (!c0_run || c0_mode != MODE_PULSE) begin
				c0_pw_q <= PW_IDLE;
			end else begin
				unique case (c0_pw_q)
					PW_IDLE:  c0_pw_q <= PW_ARMED;
					PW_ARMED: if (c0_act) c0_pw_q <= PW_COUNT;
					PW_COUNT: if (c0_ret) c0_pw_q <= PW_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c1_pw_q <= PW_IDLE;
		end else if (ce_i) begin
			if (!c1_run || c1_mode != MODE_PULSE) begin
				c1_pw_q <= PW_IDLE;
			end else begin
				unique case (c1_pw_q)
					PW_IDLE:  c1_pw_q <= PW_ARMED;
					PW_ARMED: if (c1_act) c1_pw_q <= PW_COUNT;
					PW_COUNT: if (c1_ret) c1_pw_q <= PW_IDLE;
				endcase
			end
		end
	end

	// Control registers; a software write beats the hardware run clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c0_ctrl_q <= CTRL_RST;
		end else if (ce_i) begin
			if (wr_c0_ctrl) begin
				c0_ctrl_q <= wbyte & C0_CTRL_MASK;
			end else if (c0_pw_done) begin
				c0_ctrl_q[RUN_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c1_ctrl_q <= CTRL_RST;
		end else if (ce_i) begin
			if (wr_c1_ctrl) begin
				c1_ctrl_q <= wbyte & C1_CTRL_MASK;
			end else if (c1_pw_done) begin
				c1_ctrl_q[RUN_BIT] <= 1'b0;
			end
		end
	end

	// Counter 0 count and preload
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c0_cnt_q <= '0;
			c0_pre_q <= '0;
		end else if (ce_i) begin
			if (wr_c0_cnt) begin
				c0_pre_q <= wbyte;
			end
			if (wr_c0_cnt && !c0_run) begin
				c0_cnt_q <= wbyte;
			end else if (c0_ovf) begin
				c0_cnt_q <= c0_pre_q;
			end else if (c0_step) begin
				c0_cnt_q <= c0_cnt_q + 8'h01;
			end
		end
	end

	// Counter 1 byte buffer, shared by write staging and read latching
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c1_buf_q <= '0;
		end else if (ce_i) begin
			if (wr_c1_low) begin
				c1_buf_q <= wbyte;
			end else if (rd_c1_high) begin
				c1_buf_q <= c1_cnt_q[7:0];
			end
		end
	end

	// Counter 1 count and preload
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c1_cnt_q <= '0;
			c1_pre_q <= '0;
		end else if (ce_i) begin
			if (wr_c1_high) begin
				c1_pre_q <= {wbyte, c1_buf_q};
			end
			if (wr_c1_high && !c1_run) begin
				c1_cnt_q <= {wbyte, c1_buf_q};
			end else if (c1_ovf) begin
				c1_cnt_q <= c1_pre_q;
			end else if (c1_step) begin
				c1_cnt_q <= c1_cnt_q + 16'h0001;
			end
		end
	end

	// Interrupt control: a hardware set wins over a software clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			interrupt_control_q <= INTERRUPT_CONTROL_RST;
		end else if (ce_i) begin
			if (wr_interrupt_control) begin
				interrupt_control_q <= wbyte & INTERRUPT_CONTROL_MASK;
			end
			if (c0_ovf) begin
				interrupt_control_q[C0_FLAG_BIT] <= 1'b1;
			end
			if (c1_ovf) begin
				interrupt_control_q[C1_FLAG_BIT] <= 1'b1;
			end
		end
	end

	assign counter0_irq_o = interrupt_control_q[C0_FLAG_BIT] && interrupt_control_q[C0_IE_BIT];
	assign counter1_irq_o = interrupt_control_q[C1_FLAG_BIT] && interrupt_control_q[C1_IE_BIT];

	// Wake pulse regardless of interrupt enables
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_o <= 1'b0;
		end else if (ce_i) begin
			wake_o <= c1_ovf || c0_ovf;
		end
	end

	// Read mux and acknowledge, one cycle after the request is taken
	always_comb begin
		rbyte = 8'h00;
		unique case (idx)
			IDX_INTERRUPT_CONTROL:     rbyte = interrupt_control_q;
			IDX_C0_COUNT: rbyte = c0_cnt_q;
			IDX_C0_CTRL:  rbyte = c0_ctrl_q;
			IDX_C1_HIGH:  rbyte = c1_cnt_q[15:8];
			IDX_C1_LOW:   rbyte = c1_buf_q;
			IDX_C1_CTRL:  rbyte = c1_ctrl_q;
			default:      rbyte = 8'h00;
		endcase
		if (!mapped_hi) begin
			rbyte = 8'h00;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else if (ce_i) begin
			wb_ack_o <= take;
			if (take) begin
				wb_dat_o <= {24'h000000, rbyte};
			end
		end
	end

	// Checks
	a_c1_ovf_reload: assert property (@(posedge clk_i)
		disable iff (rst_i) (ce_i && c1_ovf && !wr_c1_high) |=>
		(c1_cnt_q == $past(c1_pre_q) && interrupt_control_q[C1_FLAG_BIT]))
		else $error("counter 1 overflow did not reload and flag");

	a_c0_ovf_reload: assert property (@(posedge clk_i)
		disable iff (rst_i) (ce_i && c0_ovf && !wr_c0_cnt) |=>
		(c0_cnt_q == $past(c0_pre_q) && interrupt_control_q[C0_FLAG_BIT]))
		else $error("counter 0 overflow did not reload and flag");

	a_low_write_held: assert property (@(posedge clk_i)
		disable iff (rst_i) (ce_i && wr_c1_low) |=>
		(c1_pre_q == $past(c1_pre_q) && c1_buf_q == $past(wbyte)))
		else $error("low byte write reached preload");

	a_high_read_latch: assert property (@(posedge clk_i)
		disable iff (rst_i) (ce_i && rd_c1_high) |=>
		(c1_buf_q == $past(c1_cnt_q[7:0]) && $stable(c1_cnt_q)))
		else $error("high byte read did not latch or hold count");

	a_pw_run_clear: assert property (@(posedge clk_i)
		disable iff (rst_i) (ce_i && c1_pw_done && !wr_c1_ctrl) |=>
		(!c1_ctrl_q[RUN_BIT] && c1_pw_q == PW_IDLE))
		else $error("pulse end did not clear run");

	a_unused_mode_idle: assert property (@(posedge clk_i)
		disable iff (rst_i) (ce_i && c1_mode == MODE_UNUSED && !wr_c1_high)
		|=> $stable(c1_cnt_q))
		else $error("counter 1 counted in unused mode");

	a_stopped_preload: assert property (@(posedge clk_i)
		disable iff (rst_i) (ce_i && wr_c1_high && !c1_run) |=>
		(c1_cnt_q == c1_pre_q && c1_cnt_q[15:8] == $past(wbyte)))
		else $error("stopped preload write did not load counter");

	a_irq_follows_ovf: assert property (@(posedge clk_i)
		disable iff (rst_i) (ce_i && c1_ovf && !wr_interrupt_control) |=>
		(counter1_irq_o == interrupt_control_q[C1_IE_BIT]) && wake_o)
		else $error("counter 1 request or wake wrong after overflow");

	a_unused_bits_zero: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(c1_ctrl_q[2:0] == 3'h0) && !c1_ctrl_q[5] && !c0_ctrl_q[5])
		else $error("unimplemented control bit set");

	a_bus_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && take) |=> wb_ack_o ##1 (!wb_ack_o || !ce_i))
		else $error("ack not a single cycle");

endmodule : dual_timer

//--- core/pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for a pin.
// Assumes: Pin is asynchronous to clk_i.
// Notes:   Output follows once stages two and three agree.
`timescale 1ns/100ps
module pin_sync (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// Pin and filtered level
	input  wire logic pin_i,
	output logic      level_o
);

	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q    <= 1'b0;
			s2_q    <= 1'b0;
			s3_q    <= 1'b0;
			level_o <= 1'b0;
		end else if (ce_i) begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_o <= s3_q;
			end
		end
	end

endmodule : pin_sync

//--- core/tick_divider.sv
// Purpose: Free-running divider giving a one-cycle tick every 2^(sel+1).
// Assumes: sel 0 divides by 2, sel 7 by 256.
// Notes:   Cleared by reset so the first tick is deterministic.
`timescale 1ns/100ps
module tick_divider (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	// Divide select and tick
	input  wire logic [2:0] div_sel_i,
	output logic            tick_o
);
	import timer_pkg::*;

	logic [PSC_CNT_W-1:0] cnt_q;
	logic [PSC_CNT_W-1:0] mask;

	assign mask   = 8'hFF >> (3'h7 - div_sel_i);
	assign tick_o = &(cnt_q | ~mask);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else if (ce_i) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

endmodule : tick_divider

//--- include/timer_pkg.sv
// Purpose: Shared constants for the dual timer/event counter block.
// Assumes: Register indices are word indices; byte address is 4 x index.
// Notes:   Control reset value leaves the edge select at high-to-low.
package timer_pkg;

	// Register word indices
	localparam logic [4:0] IDX_INTERRUPT_CONTROL      = 5'h0B;
	localparam logic [4:0] IDX_C0_COUNT  = 5'h0D;
	localparam logic [4:0] IDX_C0_CTRL   = 5'h0E;
	localparam logic [4:0] IDX_C1_HIGH   = 5'h0F;
	localparam logic [4:0] IDX_C1_LOW    = 5'h10;
	localparam logic [4:0] IDX_C1_CTRL   = 5'h11;

	// Control field positions
	localparam int         PSC_LSB       = 0;
	localparam int         EDGE_BIT      = 3;
	localparam int         RUN_BIT       = 4;
	localparam int         MODE_LSB      = 6;

	// Interrupt control field positions
	localparam int         C0_IE_BIT     = 2;
	localparam int         C1_IE_BIT     = 3;
	localparam int         C0_FLAG_BIT   = 5;
	localparam int         C1_FLAG_BIT   = 6;

	// Implemented bits and reset values
	localparam logic [7:0] C0_CTRL_MASK  = 8'hDF;
	localparam logic [7:0] C1_CTRL_MASK  = 8'hD8;
	localparam logic [7:0] INTERRUPT_CONTROL_MASK     = 8'h6C;
	localparam logic [7:0] CTRL_RST      = 8'h08;
	localparam logic [7:0] INTERRUPT_CONTROL_RST      = 8'h00;

	// Mode field codes
	localparam logic [1:0] MODE_UNUSED   = 2'h0;
	localparam logic [1:0] MODE_EVENT    = 2'h1;
	localparam logic [1:0] MODE_TIMER    = 2'h2;
	localparam logic [1:0] MODE_PULSE    = 2'h3;

	// Instruction clock is system clock divided by 4
	localparam logic [2:0] INSTR_DIV_SEL = 3'h1;
	localparam int         PSC_CNT_W     = 8;

	typedef enum logic [1:0] {
		PW_IDLE,
		PW_ARMED,
		PW_COUNT
	} pw_state_e;

endpackage : timer_pkg

//--- tb/dual_timer_event_counter_tb.sv
// Purpose: Self-checking bench for the dual timer over Wishbone.
// Assumes: Ack one cycle after the taking edge; ce_i held high.
// Notes:   Tick-based counts allow a small window for bus latency.
`timescale 1ns/100ps
module dual_timer_event_counter_tb;
	import timer_pkg::*;

	localparam logic [7:0] A_INTERRUPT_CONTROL = {1'b0, IDX_INTERRUPT_CONTROL, 2'b00};
	localparam logic [7:0] A_C0CN = {1'b0, IDX_C0_COUNT, 2'b00};
	localparam logic [7:0] A_C0CT = {1'b0, IDX_C0_CTRL, 2'b00};
	localparam logic [7:0] A_C1HI = {1'b0, IDX_C1_HIGH, 2'b00};
	localparam logic [7:0] A_C1LO = {1'b0, IDX_C1_LOW, 2'b00};
	localparam logic [7:0] A_C1CT = {1'b0, IDX_C1_CTRL, 2'b00};

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        ce_i = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [31:0] wb_dat = 32'h0;
	logic [3:0]  wb_sel = 4'h0;
	logic [3:0]  sel_use = 4'h1;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        pin0, pin1, irq0, irq1, wake;
	logic [15:0] v;
	logic [15:0] w;
	int          bad_count = 0;
	int          samples_checked = 0;
	int          wake_seen = 0;

	always #4 clk_i = ~clk_i;

	dual_timer dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.counter0_input_pin_i(pin0), .counter1_input_pin_i(pin1),
		.counter0_irq_o(irq0), .counter1_irq_o(irq1), .wake_o(wake)
	);

	pin_source src (.clk_i(clk_i), .pin0_o(pin0), .pin1_o(pin1));

	always @(posedge clk_i) begin
		if (wake === 1'b1) begin
			wake_seen <= wake_seen + 1;
		end
	end

	task automatic summarize;
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	task automatic check(input string what, input logic [15:0] exp,
			input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic near(input string what, input int lo, input int hi,
			input logic [15:0] got);
		samples_checked++;
		if ($isunknown(got) || got < lo || got > hi) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", what,
				lo, hi, got);
		end
	endtask : near

	// Hold the request until ack is sampled, then leave one idle edge
	task automatic bus(input logic we, input logic [7:0] a,
			input logic [7:0] d, output logic [7:0] r);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_sel <= sel_use;
		wb_adr <= a;
		wb_dat <= {24'h0, d};
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		r = wb_dat_o[7:0];
		if (n == 50) begin
			bad_count++;
		end
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_sel <= 4'h0;
		@(posedge clk_i);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	task automatic rdchk(input string what, input logic [7:0] a,
			input logic [7:0] exp);
		logic [7:0] r;
		bus(1'b0, a, 8'h00, r);
		check(what, {8'h00, exp}, {8'h00, r});
	endtask : rdchk

	task automatic get_count(input int c, output logic [15:0] cnt);
		logic [7:0] h, l;
		h = 8'h00;
		if (c == 0) begin
			bus(1'b0, A_C0CN, 8'h00, l);
		end else begin
			bus(1'b0, A_C1HI, 8'h00, h);
			bus(1'b0, A_C1LO, 8'h00, l);
		end
		cnt = {h, l};
	endtask : get_count

	task automatic load(input int c, input logic [15:0] d);
		if (c == 0) begin
			wr(A_C0CN, d[7:0]);
		end else begin
			wr(A_C1LO, d[7:0]);
			wr(A_C1HI, d[15:8]);
		end
	endtask : load

	task automatic wait_irq(input int c);
		int n;
		n = 0;
		while ((c ? irq1 : irq0) !== 1'b1 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		check("irq raised", 16'h1, {15'h0, c ? irq1 : irq0});
	endtask : wait_irq

	initial begin
		repeat (40000) @(posedge clk_i);
		bad_count++;
		summarize();
	end

	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdchk("ctrl0 reset", A_C0CT, 8'h08);
		rdchk("ctrl1 reset", A_C1CT, 8'h08);
		wr(A_C0CT, 8'hFF);
		rdchk("ctrl0 unused bit", A_C0CT, 8'hDF);
		wr(A_C1CT, 8'hFF);
		rdchk("ctrl1 unused bits", A_C1CT, 8'hD8);
		wr(A_C0CT, 8'h00);
		wr(A_C1CT, 8'h00);
		sel_use = 4'h0;
		wr(A_C0CT, 8'hFF);
		sel_use = 4'h1;
		rdchk("sel ignored", A_C0CT, 8'h00);
		wr(8'h80, 8'h5A);
		rdchk("unmapped", 8'h80, 8'h00);
		wr(A_INTERRUPT_CONTROL, 8'hFF);
		rdchk("interrupt_control bits", A_INTERRUPT_CONTROL, 8'h6C);
		check("irq pair", 16'h3, {14'h0, irq1, irq0});
		wr(A_INTERRUPT_CONTROL, 8'h00);
		load(1, 16'h1234);
		rdchk("c1 high", A_C1HI, 8'h12);
		rdchk("c1 latched low", A_C1LO, 8'h34);
		wr(A_C1LO, 8'h56);
		rdchk("c1 buffer", A_C1LO, 8'h56);
		rdchk("c1 high kept", A_C1HI, 8'h12);
		// Event mode, both counters, both edge selections
		for (int c = 0; c < 2; c++) begin
			for (int e = 0; e < 2; e++) begin
				wr(c ? A_C1CT : A_C0CT, 8'h00);
				load(c, 16'h0000);
				wr(c ? A_C1CT : A_C0CT, 8'h50 | (e << 3));
				repeat (8) @(posedge clk_i);
				src.level(c, 1'b1);
				repeat (10) @(posedge clk_i);
				get_count(c, v);
				check("edge rise", e ? 16'h0 : 16'h1, v);
				src.level(c, 1'b0);
				repeat (10) @(posedge clk_i);
				get_count(c, v);
				check("edge fall", 16'h1, v);
			end
			wr(c ? A_C1CT : A_C0CT, 8'h00);
		end
		// Counter 1 timer overflow, reload, flag, enable
		load(1, 16'hFFF0);
		wr(A_INTERRUPT_CONTROL, 8'h08);
		wr(A_C1CT, 8'h90);
		wait_irq(1);
		rdchk("interrupt_control c1 flag", A_INTERRUPT_CONTROL, 8'h48);
		rdchk("c1 run kept", A_C1CT, 8'h90);
		get_count(1, v);
		near("c1 reload", 16'hFFF0, 16'hFFFF, v);
		near("wake", 1, 100, wake_seen);
		wr(A_INTERRUPT_CONTROL, 8'h00);
		repeat (100) @(posedge clk_i);
		check("irq1 masked", 16'h0, {15'h0, irq1});
		rdchk("flag only", A_INTERRUPT_CONTROL, 8'h40);
		// Pulse width, single shot and rearm
		wr(A_C1CT, 8'h00);
		load(1, 16'h0000);
		wr(A_C1CT, 8'hD0);
		repeat (4) @(posedge clk_i);
		src.pulse(1, 40);
		repeat (10) @(posedge clk_i);
		rdchk("run cleared", A_C1CT, 8'hC0);
		get_count(1, v);
		near("pulse width", 9, 11, v);
		src.pulse(1, 40);
		repeat (10) @(posedge clk_i);
		get_count(1, v);
		near("result held", 9, 11, v);
		wr(A_C1CT, 8'hD0);
		repeat (4) @(posedge clk_i);
		src.pulse(1, 20);
		repeat (10) @(posedge clk_i);
		get_count(1, v);
		near("rearmed", 14, 16, v);
		// A level is no trigger; overflow while measuring reloads
		wr(A_INTERRUPT_CONTROL, 8'h00);
		wr(A_C1CT, 8'h00);
		load(1, 16'hFFF8);
		src.level(1, 1'b1);
		repeat (10) @(posedge clk_i);
		wr(A_C1CT, 8'hD0);
		repeat (20) @(posedge clk_i);
		src.level(1, 1'b0);
		repeat (10) @(posedge clk_i);
		get_count(1, v);
		check("level no start", 16'hFFF8, v);
		src.pulse(1, 80);
		repeat (10) @(posedge clk_i);
		get_count(1, v);
		near("pulse overflow", 16'hFFFB, 16'hFFFD, v);
		rdchk("pulse flag", A_INTERRUPT_CONTROL, 8'h40);
		w = v;
		wr(A_C1CT, 8'h10);
		repeat (40) @(posedge clk_i);
		get_count(1, v);
		check("c1 mode unused", w, v);
		wr(A_C1CT, 8'h00);
		// Counter 0 prescaler codes
		for (int p = 0; p < 8; p++) begin
			wr(A_C0CT, 8'h00);
			load(0, 16'h0000);
			wr(A_C0CT, 8'h90 | p);
			repeat (256) @(posedge clk_i);
			wr(A_C0CT, 8'h00);
			get_count(0, v);
			near("prescale", (256 >> (p + 1)) - 1, (256 >> (p + 1)) + 3,
				v);
		end
		load(0, 16'h0000);
		wr(A_C0CT, 8'h10);
		repeat (256) @(posedge clk_i);
		get_count(0, v);
		check("mode unused", 16'h0, v);
		wr(A_C0CT, 8'h00);
		load(0, 16'h00F0);
		wr(A_INTERRUPT_CONTROL, 8'h04);
		wr(A_C0CT, 8'h90);
		wait_irq(0);
		rdchk("interrupt_control c0 flag", A_INTERRUPT_CONTROL, 8'h24);
		wr(A_C0CN, 8'h20);
		get_count(0, v);
		near("c0 preload only", 16'hF0, 16'hFF, v);
		wr(A_C0CT, 8'h00);
		summarize();
	end
endmodule : dual_timer_event_counter_tb

//--- tb/pin_source.sv
// Purpose: Far-side source of events and pulses on the counter pins.
// Assumes: Callers enter the tasks just after a rising clock edge.
// Notes:   Pins are driven levels; no pull-up applies here.
`timescale 1ns/100ps
module pin_source (
	// Clock
	input  wire logic clk_i,
	// Pin levels
	output logic      pin0_o,
	output logic      pin1_o
);
	initial begin
		pin0_o = 1'b0;
		pin1_o = 1'b0;
	end

	task automatic level(input int c, input logic v);
		if (c == 0) begin
			pin0_o <= v;
		end else begin
			pin1_o <= v;
		end
	endtask : level

	// Width in clocks, so both prompt and slow sources can be modelled
	task automatic pulse(input int c, input int width);
		level(c, 1'b1);
		repeat (width) @(posedge clk_i);
		level(c, 1'b0);
	endtask : pulse
endmodule : pin_source
